// [src/output_current_detector.v]
`include "curdet_consts.vh"
module output_current_detector #(
    parameter integer TICK_DIV  = `CLK_KHZ * `TICK_MS,
    parameter integer RESP_TICK = `RESPONSE_MS / `TICK_MS,
    parameter integer NTERM     = 7
) (
    input  wire             CORE_CLK,
    input  wire             RESET,
    input  wire             WB_CYC_I,
    input  wire             WB_STB_I,
    input  wire             WB_WE_I,
    input  wire [7:0]       WB_ADR_I,
    input  wire [3:0]       WB_SEL_I,
    input  wire [31:0]      WB_DAT_I,
    output reg  [31:0]      WB_DAT_O,
    output wire             WB_ACK_O,
    input  wire [7:0]       CURRENT_PCT,
    output wire [NTERM-1:0] TERMINAL,
    output wire             OUTPUT_STOP,
    output wire             IRQ
);
    localparam integer ZMIN = `ZERO_MIN_MS / `TICK_MS;

    reg  [7:0]  oc_level;
    reg  [15:0] oc_delay;
    reg  [7:0]  zero_level;
    reg  [15:0] zero_time;
    reg  [15:0] retention;
    reg         action_req;
    reg         action;
    reg  [7:0]  term_sel [0:NTERM-1];
    reg         run;
    reg         tune;
    reg  [`IRQ_W-1:0] irq_status;
    reg  [`IRQ_W-1:0] irq_mask;
    reg         ack;

    reg  [15:0] oc_count;
    reg  [15:0] ret_count;
    reg  [15:0] zero_count;
    reg  [7:0]  zmin_count;
    reg         oc_flag;
    reg         zero_flag;
    reg         alarm;
    reg         oc_flag_d;
    reg         zero_flag_d;
    reg         alarm_d;

    wire        tick;
    wire        oc_term;
    wire        zero_term;
    wire        wr;
    wire        start_pulse;
    wire        alarm_clr;
    wire        active;
    wire        over;
    wire        under;
    wire        hold_mode;
    wire [`IRQ_W-1:0] events;
    integer     i;

    function [7:0] sel_byte;
        input [31:0] data;
        input [3:0]  sel;
        input [7:0]  old;
        begin
            sel_byte = sel[0] ? data[7:0] : old;
        end
    endfunction

    function [15:0] sel_half;
        input [31:0] data;
        input [3:0]  sel;
        input [15:0] old;
        begin
            sel_half = {sel[1] ? data[15:8] : old[15:8], sel[0] ? data[7:0] : old[7:0]};
        end
    endfunction

    // One-shot strobe from a written control bit
    function ctl_strobe;
        input       strobe;
        input [7:0] adr;
        input       sel0;
        input       data_bit;
        begin
            ctl_strobe = strobe & (adr == `REG_CONTROL) & sel0 & data_bit;
        end
    endfunction

    // Route a flag by terminal code
    function term_drive;
        input [7:0] code;
        input       oc;
        input       zc;
        begin
            case (code)
                `FN_OC_POS:   term_drive = oc;
                `FN_OC_NEG:   term_drive = ~oc;
                `FN_ZERO_POS: term_drive = zc;
                `FN_ZERO_NEG: term_drive = ~zc;
                default:      term_drive = 1'b0;
            endcase
        end
    endfunction

    tick_gen #(
        .DIV(TICK_DIV)
    ) u_tick (
        .CORE_CLK(CORE_CLK),
        .RESET   (RESET),
        .tick    (tick)
    );

    resp_delay #(
        .TICKS(RESP_TICK)
    ) u_oc_resp (
        .CORE_CLK(CORE_CLK),
        .RESET   (RESET),
        .tick    (tick),
        .din     (oc_flag),
        .dout    (oc_term)
    );

    resp_delay #(
        .TICKS(RESP_TICK)
    ) u_zero_resp (
        .CORE_CLK(CORE_CLK),
        .RESET   (RESET),
        .tick    (tick),
        .din     (zero_flag),
        .dout    (zero_term)
    );

    genvar g;
    generate
        for (g = 0; g < NTERM; g = g + 1) begin : g_term
            assign TERMINAL[g] = term_drive(term_sel[g], oc_term, zero_term);
        end
    endgenerate

    // Writes land on the edge at which the master sees ack
    assign wr          = WB_CYC_I & WB_STB_I & WB_WE_I & ack;
    assign WB_ACK_O    = ack;
    assign start_pulse = ctl_strobe(wr, WB_ADR_I, WB_SEL_I[0], WB_DAT_I[`CTL_START]);
    assign alarm_clr   = ctl_strobe(wr, WB_ADR_I, WB_SEL_I[0], WB_DAT_I[`CTL_ALARM_CLR]);
    // Tuning runs the output too, so detection stays live
    assign active      = (run | tune) & ~alarm;
    assign over        = CURRENT_PCT > oc_level;
    assign under       = CURRENT_PCT < zero_level;
    assign hold_mode   = retention == `RETENTION_HOLD;
    assign OUTPUT_STOP = alarm;
    assign events      = {alarm & ~alarm_d, zero_flag & ~zero_flag_d, oc_flag & ~oc_flag_d};
    assign IRQ         = |(irq_status & irq_mask);

    always @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            ack        <= 1'b0;
            oc_level   <= `RST_OC_LEVEL;
            oc_delay   <= `RST_OC_DELAY;
            zero_level <= `RST_ZERO_LEVEL;
            zero_time  <= `RST_ZERO_TIME;
            retention  <= `RST_RETENTION;
            action_req <= 1'b0;
            run        <= 1'b0;
            tune       <= 1'b0;
            irq_mask   <= {`IRQ_W{1'b0}};
            for (i = 0; i < NTERM; i = i + 1) begin
                term_sel[i] <= `RST_TERM_SEL;
            end
        end else begin
            ack <= WB_CYC_I & WB_STB_I & ~ack;
            if (wr) begin
                case (WB_ADR_I)
                    `REG_OC_LEVEL:   oc_level   <= sel_byte(WB_DAT_I, WB_SEL_I, oc_level);
                    `REG_OC_DELAY:   oc_delay   <= sel_half(WB_DAT_I, WB_SEL_I, oc_delay);
                    `REG_ZERO_LEVEL: zero_level <= sel_byte(WB_DAT_I, WB_SEL_I, zero_level);
                    `REG_ZERO_TIME:  zero_time  <= sel_half(WB_DAT_I, WB_SEL_I, zero_time);
                    `REG_RETENTION:  retention  <= sel_half(WB_DAT_I, WB_SEL_I, retention);
                    `REG_ACTION: begin
                        if (WB_SEL_I[0]) begin
                            action_req <= WB_DAT_I[0];
                        end
                    end
                    `REG_TERM_SEL: begin
                        for (i = 0; i < 4; i = i + 1) begin
                            if (i < NTERM && WB_SEL_I[i]) begin
                                term_sel[i] <= WB_DAT_I[i*8 +: 8];
                            end
                        end
                    end
                    `REG_CONTROL: begin
                        if (WB_SEL_I[0]) begin
                            run  <= WB_DAT_I[`CTL_RUN];
                            tune <= WB_DAT_I[`CTL_TUNE];
                        end
                    end
                    `REG_IRQ_MASK: begin
                        if (WB_SEL_I[0]) begin
                            irq_mask <= WB_DAT_I[`IRQ_W-1:0];
                        end
                    end
                    `REG_CURRENT: begin
                        for (i = 4; i < NTERM; i = i + 1) begin
                            if (WB_SEL_I[i-4]) begin
                                term_sel[i] <= WB_DAT_I[(i-4)*8 +: 8];
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Sticky interrupt bits: a new event beats a write-one clear
    always @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            irq_status <= {`IRQ_W{1'b0}};
        end else if (wr && WB_ADR_I == `REG_IRQ_STATUS && WB_SEL_I[0]) begin
            irq_status <= (irq_status & ~WB_DAT_I[`IRQ_W-1:0]) | events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    // Overcurrent detection, retention and alarm
    always @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            oc_count  <= 16'h0000;
            ret_count <= 16'h0000;
            oc_flag   <= 1'b0;
            alarm     <= 1'b0;
            action    <= 1'b0;
            oc_flag_d <= 1'b0;
            alarm_d   <= 1'b0;
        end else begin
            oc_flag_d <= oc_flag;
            alarm_d   <= alarm;
            if (!oc_flag) begin
                action <= action_req;
            end
            if (alarm_clr) begin
                alarm <= 1'b0;
            end
            if (!active || !over) begin
                oc_count <= 16'h0000;
            end else if (tick && !oc_flag) begin
                if (oc_count >= oc_delay) begin
                    oc_flag   <= 1'b1;
                    ret_count <= 16'h0000;
                    if (action) begin
                        alarm <= 1'b1;
                    end
                end else begin
                    oc_count <= oc_count + 16'h0001;
                end
            end
            if (oc_flag) begin
                if (hold_mode) begin
                    if (alarm_clr || (start_pulse && !alarm)) begin
                        oc_flag <= 1'b0;
                    end
                end else if (active && over) begin
                    // Retention runs once the condition lapses, so no gap while it persists
                    ret_count <= 16'h0000;
                end else if (tick) begin
                    if (ret_count >= retention) begin
                        oc_flag <= 1'b0;
                    end else begin
                        ret_count <= ret_count + 16'h0001;
                    end
                end
            end
        end
    end

    // Zero-current detection with minimum on-time
    always @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            zero_count  <= 16'h0000;
            zmin_count  <= 8'h00;
            zero_flag   <= 1'b0;
            zero_flag_d <= 1'b0;
        end else begin
            zero_flag_d <= zero_flag;
            if (!active || !under) begin
                zero_count <= 16'h0000;
            end else if (tick && zero_count < zero_time) begin
                zero_count <= zero_count + 16'h0001;
            end
            if (!zero_flag) begin
                zmin_count <= 8'h00;
                if (active && under && tick && zero_count >= zero_time) begin
                    zero_flag <= 1'b1;
                end
            end else begin
                if (tick && zmin_count < ZMIN) begin
                    zmin_count <= zmin_count + 8'h01;
                end
                if (zmin_count >= ZMIN && !(active && under)) begin
                    zero_flag <= 1'b0;
                end
            end
        end
    end

    always @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            WB_DAT_O <= 32'h00000000;
        end else begin
            case (WB_ADR_I)
                `REG_OC_LEVEL:   WB_DAT_O <= {24'h000000, oc_level};
                `REG_OC_DELAY:   WB_DAT_O <= {16'h0000, oc_delay};
                `REG_ZERO_LEVEL: WB_DAT_O <= {24'h000000, zero_level};
                `REG_ZERO_TIME:  WB_DAT_O <= {16'h0000, zero_time};
                `REG_RETENTION:  WB_DAT_O <= {16'h0000, retention};
                `REG_ACTION:     WB_DAT_O <= {30'h0, action, action_req};
                `REG_TERM_SEL:   WB_DAT_O <= {term_sel[3], term_sel[2], term_sel[1], term_sel[0]};
                `REG_CONTROL:    WB_DAT_O <= {30'h0, tune, run};
                `REG_STATUS:     WB_DAT_O <= {27'h0, zero_term, oc_term, alarm,
                                              zero_flag, oc_flag};
                `REG_IRQ_STATUS: WB_DAT_O <= {29'h0, irq_status};
                `REG_IRQ_MASK:   WB_DAT_O <= {29'h0, irq_mask};
                `REG_CURRENT:    WB_DAT_O <= {8'h00, term_sel[6], term_sel[5], term_sel[4]};
                default:         WB_DAT_O <= 32'h00000000;
            endcase
        end
    end
endmodule

// [common/curdet_consts.vh]
`ifndef CURDET_CONSTS_VH
`define CURDET_CONSTS_VH
// Register byte offsets
`define REG_OC_LEVEL     8'h00
`define REG_OC_DELAY     8'h04
`define REG_ZERO_LEVEL   8'h08
`define REG_ZERO_TIME    8'h0C
`define REG_RETENTION    8'h10
`define REG_ACTION       8'h14
`define REG_TERM_SEL     8'h18
`define REG_CONTROL      8'h1C
`define REG_STATUS       8'h20
`define REG_IRQ_STATUS   8'h24
`define REG_IRQ_MASK     8'h28
`define REG_CURRENT      8'h2C
// Reset values; times in units of 10 ms, levels in percent
`define RST_OC_LEVEL     8'h96
`define RST_OC_DELAY     16'h0000
`define RST_ZERO_LEVEL   8'h05
`define RST_ZERO_TIME    16'h0032
`define RST_RETENTION    16'h000A
`define RETENTION_HOLD   16'h270F
`define RST_TERM_SEL     8'h00
// Terminal function codes
`define FN_OC_POS        8'h0C
`define FN_OC_NEG        8'h70
`define FN_ZERO_POS      8'h0D
`define FN_ZERO_NEG      8'h71
// Timing
`define TICK_MS          10
`define ZERO_MIN_MS      100
`define RESPONSE_MS      350
`define CLK_KHZ          200000
// Control bits
`define CTL_RUN          0
`define CTL_TUNE         1
`define CTL_START        2
`define CTL_ALARM_CLR    3
// Irq bits
`define IRQ_OC           0
`define IRQ_ZERO         1
`define IRQ_ALARM        2
`define IRQ_W            3
`endif

// [src/tick_gen.v]
`include "curdet_consts.vh"
module tick_gen #(
    parameter integer DIV = `CLK_KHZ * `TICK_MS
) (
    input  wire CORE_CLK,
    input  wire RESET,
    output reg  tick
);
    reg [31:0] count;

    always @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            count <= 32'h00000000;
            tick  <= 1'b0;
        end else if (count == DIV - 1) begin
            count <= 32'h00000000;
            tick  <= 1'b1;
        end else begin
            count <= count + 32'h00000001;
            tick  <= 1'b0;
        end
    end
endmodule

// [src/resp_delay.v]
`include "curdet_consts.vh"
module resp_delay #(
    parameter integer TICKS = `RESPONSE_MS / `TICK_MS
) (
    input  wire CORE_CLK,
    input  wire RESET,
    input  wire tick,
    input  wire din,
    output reg  dout
);
    // Output follows input only after it has been stable for TICKS ticks
    reg [7:0] count;

    always @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
            count <= 8'h00;
            dout  <= 1'b0;
        end else if (din == dout) begin
            count <= 8'h00;
        end else if (tick) begin
            if (count == TICKS - 1) begin
                dout  <= din;
                count <= 8'h00;
            end else begin
                count <= count + 8'h01;
            end
        end
    end
endmodule

// [dv/curdet_props.sv]
module curdet_props #(
    parameter integer NTERM = 7
) (
    input wire             CORE_CLK,
    input wire             RESET,
    input wire             WB_CYC_I,
    input wire             WB_STB_I,
    input wire             WB_WE_I,
    input wire [7:0]       WB_ADR_I,
    input wire [3:0]       WB_SEL_I,
    input wire [31:0]      WB_DAT_I,
    input wire [31:0]      WB_DAT_O,
    input wire             WB_ACK_O,
    input wire [7:0]       CURRENT_PCT,
    input wire [NTERM-1:0] TERMINAL,
    input wire             OUTPUT_STOP,
    input wire             IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);
    wire wr  = WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0];
    wire clr = wr && WB_ADR_I == 8'h1C && WB_DAT_I[3];
    sequence s_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_ack;
        WB_ACK_O ##1 !WB_ACK_O;
    endsequence
    property p_ack_next;
        s_req |=> s_ack;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
    property p_ack_cause;
        $rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_ack_idle;
        !WB_CYC_I ##1 !WB_CYC_I |-> !WB_ACK_O;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack while bus idle");
    property p_unmapped;
        WB_ACK_O && !WB_WE_I && WB_ADR_I > 8'h2C |-> WB_DAT_O == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_reset_quiet;
        $fell(RESET) |-> TERMINAL == '0 && !OUTPUT_STOP && !IRQ;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
    property p_irq_masked;
        WB_ACK_O && wr && WB_ADR_I == 8'h28 && WB_DAT_I[2:0] == 3'h0 |-> ##2 !IRQ;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq high with mask clear");
    property p_stop_cause;
        $rose(OUTPUT_STOP) |-> $past(CURRENT_PCT) != 8'h00;
    endproperty
    a_stop_cause: assert property (p_stop_cause) else $error("stop without current");
    property p_stop_release;
        $fell(OUTPUT_STOP) |-> $past(clr) || $past(clr, 2);
    endproperty
    a_stop_release: assert property (p_stop_release) else $error("stop fell unasked");
endmodule

bind output_current_detector curdet_props #(.NTERM(NTERM)) u_props (
    .CORE_CLK(CORE_CLK), .RESET(RESET), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CURRENT_PCT(CURRENT_PCT),
    .TERMINAL(TERMINAL), .OUTPUT_STOP(OUTPUT_STOP), .IRQ(IRQ));

// [dv/term_listener.sv]
module term_listener #(
    parameter integer NTERM = 7
) (
    input wire               CORE_CLK,
    input wire               RESET,
    input wire [NTERM-1:0]   TERMINAL,
    output logic [NTERM-1:0] seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // External equipment latches the terminal levels once per clock
    always @(posedge CORE_CLK or posedge RESET) begin
        if (RESET)
            seen <= '0;
        else
            seen <= TERMINAL;
    end
endmodule

// [dv/output_current_detector_tb_top.sv]
module output_current_detector_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam integer TD = 4;
    localparam integer RT = 3;
    localparam logic [7:0]  RA [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h24, 8'h40};
    localparam logic [31:0] RV [8] = '{32'h96, 32'h0, 32'h5, 32'h32, 32'hA, 32'h0, 32'h0, 32'h0};
    logic        CORE_CLK = 1'b0;
    logic        RESET = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [7:0]  cur = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] lfsr = 32'hD6A4;
    logic [63:0] e;
    logic [63:0] expq [$];
    wire  [31:0] rdat;
    wire         ack;
    wire         stop;
    wire         irq;
    wire  [6:0]  term;
    wire  [6:0]  seen;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          cycles = 0;

    output_current_detector #(.TICK_DIV(TD), .RESP_TICK(RT)) u_dut (
        .CORE_CLK(CORE_CLK), .RESET(RESET), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .CURRENT_PCT(cur), .TERMINAL(term), .OUTPUT_STOP(stop), .IRQ(irq));
    term_listener u_far (.CORE_CLK(CORE_CLK), .RESET(RESET), .TERMINAL(term), .seen(seen));

    initial begin
        forever #2.5 CORE_CLK = ~CORE_CLK;
    end

    task final_report;
        if (expq.size() != 0)
            n_mismatch++;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Read results are compared against the oldest noted expectation
    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            final_report();
        end else if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) begin
            e = expq.pop_front();
            chk(rdat & e[31:0], e[63:32]);
        end
    end

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        // Ends on ack; only the bench timeout ends this wait if ack never comes
        do
            @(posedge CORE_CLK);
        while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge CORE_CLK);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        expq.push_back({x, m});
        bus(1'b0, a, 32'h0);
    endtask

    task ticks(input int t);
        repeat (t * TD) @(posedge CORE_CLK);
    endtask

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    initial begin
        repeat (8) @(posedge CORE_CLK);
        RESET <= 1'b0;
        for (int i = 0; i < 8; i++)
            rd(RA[i], RV[i], 32'hFFFFFFFF);
        $display("test reset_values done");
        wr(8'h00, 32'h64);
        wr(8'h04, 32'h5);
        wr(8'h10, 32'h2);
        wr(8'h18, 32'h710D700C);
        wr(8'h2C, 32'h000D700C);
        rd(8'h2C, 32'h000D700C, 32'hFFFFFFFF);
        wr(8'h1C, 32'h1);
        cur <= 8'h65;
        ticks(3);
        for (int i = 0; i < 8; i++) begin
            lfsr = lfsr_next(lfsr);
            cur <= 8'h32 + lfsr[7:0] % 8'h33;
            @(posedge CORE_CLK);
        end
        cur <= 8'h65;
        ticks(2);
        rd(8'h20, 32'h0, 32'h1);
        ticks(4);
        rd(8'h20, 32'h1, 32'h1);
        chk(32'(seen[1:0]), 32'h2);
        ticks(RT + 1);
        chk(32'(seen[6:0]), 32'h19);
        rd(8'h24, 32'h1, 32'h1);
        wr(8'h28, 32'h1);
        chk(32'(irq), 32'h1);
        wr(8'h24, 32'h1);
        chk(32'(irq), 32'h0);
        wr(8'h28, 32'h0);
        cur <= 8'h32;
        ticks(1);
        rd(8'h20, 32'h1, 32'h1);
        ticks(12);
        rd(8'h20, 32'h0, 32'h1);
        chk(32'(seen[6:0]), 32'h2A);
        $display("test overcurrent done");
        wr(8'h0C, 32'h3);
        wr(8'h1C, 32'h3);
        cur <= 8'h04;
        ticks(6);
        rd(8'h20, 32'h2, 32'h2);
        cur <= 8'h32;
        ticks(4);
        rd(8'h20, 32'h2, 32'h2);
        ticks(12);
        rd(8'h20, 32'h0, 32'h2);
        $display("test zero_current done");
        wr(8'h10, 32'h270F);
        wr(8'h14, 32'h0);
        cur <= 8'h78;
        ticks(7);
        wr(8'h14, 32'h1);
        rd(8'h14, 32'h1, 32'h3);
        cur <= 8'h32;
        ticks(20);
        rd(8'h20, 32'h1, 32'h1);
        chk(32'(stop), 32'h0);
        wr(8'h1C, 32'h5);
        ticks(1);
        rd(8'h20, 32'h0, 32'h1);
        cur <= 8'h78;
        ticks(7);
        chk(32'(stop), 32'h1);
        rd(8'h24, 32'h4, 32'h4);
        cur <= 8'h32;
        ticks(20);
        wr(8'h1C, 32'h5);
        rd(8'h20, 32'h5, 32'h5);
        wr(8'h1C, 32'h9);
        ticks(1);
        rd(8'h20, 32'h0, 32'h5);
        chk(32'(stop), 32'h0);
        $display("test alarm done");
        final_report();
    end
endmodule
